// ---- pkg/gfault_pkg.sv ----
// Constants and carrier types for the global fault status and syndrome bank.
// Assumes one clock domain and an AXI4-Lite master on the register side.
package gfault_pkg;

	localparam int ADDR_W = 12;

	// Address = {2'h0, region[1:0], offset[7:0]}
	localparam logic [1:0] REGION_BANK = 2'h0;
	localparam logic [1:0] REGION_ALIAS = 2'h1;

	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_RESTORE = 8'h04;
	localparam logic [7:0] OFF_SYN0 = 8'h08;
	localparam logic [7:0] OFF_SYN1 = 8'h0c;
	localparam logic [7:0] OFF_SYN2 = 8'h10;
	localparam logic [7:0] OFF_PAR_LO = 8'h14;
	localparam logic [7:0] OFF_PAR_HI = 8'h18;

	localparam int BIT_MULTI = 31;
	localparam int BIT_UNSUP = 8;
	localparam int BIT_PERM = 7;
	localparam int BIT_EXT = 6;
	localparam int BIT_CFG = 5;
	localparam int BIT_UCIRQ = 4;
	localparam int BIT_UCBANK = 3;
	localparam int BIT_SMC = 2;
	localparam int BIT_USTREAM = 1;
	localparam int BIT_ICTX = 0;

	localparam int SYN0_ATS = 6;
	localparam int SYN0_NONSECURE_ATTRIBUTE_FLAG = 5;
	localparam int SYN0_NSORIG = 4;
	localparam int SYN0_INSTR = 3;
	localparam int SYN0_PRIV = 2;
	localparam int SYN0_WRITE = 1;
	localparam int SYN0_NESTED = 0;

	localparam int SYN1_SSD_LSB = 16;

	localparam logic [31:0] STATUS_NS_MASK = 32'h8000_017f;
	localparam logic [31:0] STATUS_S_MASK = 32'h8000_01ff;
	localparam logic [31:0] SYN0_NS_MASK = 32'h0000_004f;
	localparam logic [31:0] SYN0_S_MASK = 32'h0000_003e;

	localparam logic [31:0] STATUS_RST = 32'h0000_0000;
	localparam logic [31:0] SYN_RST = 32'h0000_0000;
	localparam logic [63:0] PAR_RST = 64'h0000_0000_0000_0000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic valid;
		logic toSecure;
		logic txnNonSecure;
		logic clientNonSecure;
		logic [8:0] kind;
		logic translationOpFaultFlag;
		logic instructionAccessFlag;
		logic privilegedAccessFlag;
		logic writeAccessFlag;
		logic nested;
		logic [15:0] streamIdentifier;
		logic [15:0] securityDeterminationIndex;
	} faultEvent_t;

	typedef struct packed {
		logic valid;
		logic toSecure;
		logic [63:0] result;
	} transResult_t;

	typedef struct packed {
		logic mapped;
		logic allowed;
		logic bank;
		logic ssdVis;
		logic [7:0] off;
	} accDec_t;

endpackage

// ---- rtl/global_fault_status_syndrome_regs.sv ----
// Global fault status, restore, syndrome and translation result registers,
// banked non-secure (bank 0) and secure (bank 1), on an AXI4-Lite slave.
// Assumes fault and translation result strobes come from logic on clk.
//
// Notes on behaviour
// - Unsupported client transaction sets status bit 8, else it stays clear.
// - External abort sets bit 6; may be built as read-zero, write-ignored.
// - Configuration access fault sets bit 5; unsupported means read-zero, write-ignored.
// - Unimplemented context interrupt fault sets status bit 4.
// - Access to unimplemented context bank sets status bit 3.
// - Stream match conflict sets status bit 2.
// - Unidentifiable stream sets status bit 1.
// - Invalid context fault is recorded in status bit 0.
// - Restore write replaces whole status with written value, same layout.
// - Restore write goes to the status copy of the same bank.
// - Syndrome 0 bit 6 marks translation-op fault; reserved in secure copy.
// - Syndrome 0 bit 5 is the non-secure attribute; reserved in non-secure copy.
// - Syndrome 0 bit 4 marks non-secure origin in secure copy only.
// - Syndrome 0 bits 3,2,1 hold instruction, privileged and write attributes.
// - Syndrome 0 bit 0 marks stage 2 nested fault; reserved in secure copy.
// - Syndrome 1 holds index in 31:16, stream id in 15:0; rest zero.
// - Index field visible only to secure accesses; non-secure reads zero, ignores writes.
// - Without determination registers the index field holds an unknown value.
// - Syndrome 1 copy chosen by security state of the faulting transaction.
// - 64-bit result register holds outcome of the last global translation.
// - Writing 1 to a status bit clears it; writing 0 leaves it.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module global_fault_status_syndrome_regs #(
	parameter bit CAF_SUPPORTED = 1'b1,
	parameter bit EXT_ABORT_SUPPORTED = 1'b1,
	parameter bit SSDR_PRESENT = 1'b1,
	parameter int SID_BITS = 16,
	parameter int SSD_BITS = 16
) (
	input logic clk,
	input logic rst_b,
	input logic ce,
	input gfault_pkg::faultEvent_t fault,
	input gfault_pkg::transResult_t trans,
	input logic [gfault_pkg::ADDR_W-1:0] s_axi_awaddr,
	input logic [2:0] s_axi_awprot,
	input logic s_axi_awvalid,
	output logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [gfault_pkg::ADDR_W-1:0] s_axi_araddr,
	input logic [2:0] s_axi_arprot,
	input logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input logic s_axi_rready
);

	// Unsupported fault kinds are built as read-zero, write-ignored
	localparam logic [31:0] OFF_MASK =
		(EXT_ABORT_SUPPORTED ? 32'h0 : (32'h1 << gfault_pkg::BIT_EXT)) |
		(CAF_SUPPORTED ? 32'h0 : (32'h1 << gfault_pkg::BIT_CFG));
	localparam logic [15:0] SID_M = 16'((33'h1 << SID_BITS) - 33'h1);
	localparam logic [15:0] SSD_M = 16'((33'h1 << SSD_BITS) - 33'h1);
	localparam logic [31:0] SYN1_M = {SSD_M, SID_M};

	logic awHeld_r, wHeld_r, awready_r, wready_r, bvalid_r;
	logic arready_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic [gfault_pkg::ADDR_W-1:0] awAddr_r;
	logic [2:0] awProt_r;
	logic [31:0] wData_r, wrMask, rdWord;
	logic [3:0] wStrb_r;
	logic wrDo, firstFault;
	gfault_pkg::accDec_t wrDec, rdDec;
	logic [31:0] statusQ [2];
	logic [31:0] syn0Q [2];
	logic [31:0] syn1Q [2];
	logic [31:0] syn2Q [2];
	logic [63:0] parQ [2];

	function automatic gfault_pkg::accDec_t decode(
		input logic [gfault_pkg::ADDR_W-1:0] a,
		input logic [2:0] p
	);
		gfault_pkg::accDec_t d;
		logic [1:0] region;
		region = a[9:8];
		d.off = a[7:0];
		d.ssdVis = !p[1];
		d.mapped = (a[11:10] == 2'h0) && (a[1:0] == 2'h0)
			&& (region == gfault_pkg::REGION_BANK || region == gfault_pkg::REGION_ALIAS)
			&& (a[7:0] <= gfault_pkg::OFF_PAR_HI);
		// Alias window reaches the non-secure copy and is secure-only
		d.allowed = (region == gfault_pkg::REGION_BANK) || !p[1];
		d.bank = (region == gfault_pkg::REGION_BANK) && !p[1];
		return d;
	endfunction

	assign wrDec = decode(awAddr_r, awProt_r);
	assign wrDo = awHeld_r && wHeld_r && !bvalid_r;
	assign wrMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
	// Syndromes keep the first fault until software clears the status
	assign firstFault = (statusQ[fault.toSecure] == 32'h0);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			awHeld_r <= 1'b0;
			awready_r <= 1'b1;
			awAddr_r <= '0;
			awProt_r <= 3'h0;
		end else if (ce) begin
			if (s_axi_awvalid && awready_r) begin
				awHeld_r <= 1'b1;
				awready_r <= 1'b0;
				awAddr_r <= s_axi_awaddr;
				awProt_r <= s_axi_awprot;
			end else if (wrDo) begin
				awHeld_r <= 1'b0;
			end else if (bvalid_r && s_axi_bready) begin
				awready_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wHeld_r <= 1'b0;
			wready_r <= 1'b1;
			wData_r <= 32'h0;
			wStrb_r <= 4'h0;
		end else if (ce) begin
			if (s_axi_wvalid && wready_r) begin
				wHeld_r <= 1'b1;
				wready_r <= 1'b0;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end else if (wrDo) begin
				wHeld_r <= 1'b0;
			end else if (bvalid_r && s_axi_bready) begin
				wready_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bvalid_r <= 1'b0;
			bresp_r <= gfault_pkg::RESP_OKAY;
		end else if (ce) begin
			if (wrDo) begin
				bvalid_r <= 1'b1;
				bresp_r <= wrDec.mapped ? gfault_pkg::RESP_OKAY : gfault_pkg::RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_comb begin
		rdDec = decode(s_axi_araddr, s_axi_arprot);
		rdWord = 32'h0;
		if (rdDec.mapped && rdDec.allowed) begin
			unique case (rdDec.off)
				gfault_pkg::OFF_STATUS: rdWord = statusQ[rdDec.bank];
				gfault_pkg::OFF_SYN0: rdWord = syn0Q[rdDec.bank];
				// Index hidden from non-secure readers
				gfault_pkg::OFF_SYN1: rdWord = syn1Q[rdDec.bank]
					& (rdDec.ssdVis ? 32'hffff_ffff : 32'h0000_ffff);
				gfault_pkg::OFF_SYN2: rdWord = syn2Q[rdDec.bank];
				gfault_pkg::OFF_PAR_LO: rdWord = parQ[rdDec.bank][31:0];
				gfault_pkg::OFF_PAR_HI: rdWord = parQ[rdDec.bank][63:32];
				default: rdWord = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= gfault_pkg::RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && arready_r) begin
				arready_r <= 1'b0;
				rvalid_r <= 1'b1;
				rdata_r <= rdWord;
				rresp_r <= rdDec.mapped ? gfault_pkg::RESP_OKAY : gfault_pkg::RESP_SLVERR;
			end else if (rvalid_r && s_axi_rready) begin
				rvalid_r <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	for (genvar b = 0; b < 2; b++) begin : gBank
		// Permission flag lives only in the secure copy
		localparam logic [31:0] LIVE =
			(b == 1 ? gfault_pkg::STATUS_S_MASK : gfault_pkg::STATUS_NS_MASK) & ~OFF_MASK;
		localparam logic [31:0] SYN0_M =
			b == 1 ? gfault_pkg::SYN0_S_MASK : gfault_pkg::SYN0_NS_MASK;
		logic [31:0] status_r, status_nxt, syn0_r, syn1_r, syn2_r, setBits, cap0, cap1;
		logic [31:0] syn1WrM;
		logic [63:0] par_r;
		logic wrHere, evHit, syn1Hit;

		assign wrHere = wrDo && wrDec.mapped && wrDec.allowed && (wrDec.bank == 1'(b));
		assign evHit = fault.valid && (fault.toSecure == 1'(b));
		assign syn1Hit = fault.valid && firstFault
			&& (fault.txnNonSecure == (b == 0));
		// Each fault kind lands on its own flag where that flag is live in this copy
		assign setBits = {23'h0, fault.kind} & LIVE;
		assign cap0 = {25'h0, fault.translationOpFaultFlag,
			fault.txnNonSecure,
			fault.clientNonSecure,
			fault.instructionAccessFlag, fault.privilegedAccessFlag,
			fault.writeAccessFlag, fault.nested} & SYN0_M;
		// Index kept as delivered; with no determination registers it is unknown
		assign cap1 = {fault.securityDeterminationIndex & SSD_M,
			fault.streamIdentifier & SID_M};
		assign syn1WrM = wrMask & (wrDec.ssdVis ? SYN1_M : {16'h0, SID_M});

		always_comb begin
			status_nxt = status_r;
			if (wrHere && wrDec.off == gfault_pkg::OFF_RESTORE) begin
				// Bank-matched overwrite
				status_nxt = ((status_r & ~wrMask) | (wData_r & wrMask)) & LIVE;
			end else if (wrHere && wrDec.off == gfault_pkg::OFF_STATUS) begin
				status_nxt = status_r & ~(wData_r & wrMask & LIVE);
			end
			// New faults win over a clear in the same cycle
			if (evHit) begin
				status_nxt = status_nxt | setBits;
				if (status_r != 32'h0) begin
					status_nxt[gfault_pkg::BIT_MULTI] = 1'b1;
				end
			end
		end

		always_ff @(posedge clk) begin
			if (!rst_b) begin
				status_r <= gfault_pkg::STATUS_RST;
			end else if (ce) begin
				status_r <= status_nxt;
			end
		end

		always_ff @(posedge clk) begin
			if (!rst_b) begin
				syn0_r <= gfault_pkg::SYN_RST;
				syn2_r <= gfault_pkg::SYN_RST;
			end else if (ce) begin
				if (evHit && status_r == 32'h0) begin
					syn0_r <= cap0;
				end else if (wrHere && wrDec.off == gfault_pkg::OFF_SYN0) begin
					syn0_r <= ((syn0_r & ~wrMask) | (wData_r & wrMask)) & SYN0_M;
				end
				if (wrHere && wrDec.off == gfault_pkg::OFF_SYN2) begin
					syn2_r <= (syn2_r & ~wrMask) | (wData_r & wrMask);
				end
			end
		end

		always_ff @(posedge clk) begin
			if (!rst_b) begin
				syn1_r <= gfault_pkg::SYN_RST;
			end else if (ce) begin
				if (syn1Hit) begin
					syn1_r <= cap1;
				end else if (wrHere && wrDec.off == gfault_pkg::OFF_SYN1) begin
					syn1_r <= (syn1_r & ~syn1WrM) | (wData_r & syn1WrM);
				end
			end
		end

		always_ff @(posedge clk) begin
			if (!rst_b) begin
				par_r <= gfault_pkg::PAR_RST;
			end else if (ce) begin
				if (trans.valid && trans.toSecure == 1'(b)) begin
					par_r <= trans.result;
				end else if (wrHere && wrDec.off == gfault_pkg::OFF_PAR_LO) begin
					par_r[31:0] <= (par_r[31:0] & ~wrMask) | (wData_r & wrMask);
				end else if (wrHere && wrDec.off == gfault_pkg::OFF_PAR_HI) begin
					par_r[63:32] <= (par_r[63:32] & ~wrMask) | (wData_r & wrMask);
				end
			end
		end

		assign statusQ[b] = status_r;
		assign syn0Q[b] = syn0_r;
		assign syn1Q[b] = syn1_r;
		assign syn2Q[b] = syn2_r;
		assign parQ[b] = par_r;
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// Checks
	logic nsClearBit0, sRestore, arHs;
	assign nsClearBit0 = wrDo && wrDec.mapped && wrDec.allowed && !wrDec.bank
		&& wrDec.off == gfault_pkg::OFF_STATUS && wData_r[0] && wStrb_r[0];
	assign sRestore = wrDo && wrDec.mapped && wrDec.allowed && wrDec.bank
		&& wrDec.off == gfault_pkg::OFF_RESTORE && wStrb_r[0];
	assign arHs = s_axi_arvalid && arready_r;

	unsup_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && fault.valid && !fault.toSecure && fault.kind[8] |=> statusQ[0][8])
		else $error("unsupported flag not set");
	perm_reserved_a: assert property (@(posedge clk) disable iff (!rst_b)
		!statusQ[0][7])
		else $error("non-secure permission flag set");
	ext_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && fault.valid && fault.toSecure && fault.kind[6]
		|=> statusQ[1][6] == EXT_ABORT_SUPPORTED)
		else $error("external abort flag wrong");
	cfg_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && fault.valid && !fault.toSecure && fault.kind[5]
		|=> statusQ[0][5] == CAF_SUPPORTED)
		else $error("configuration fault flag wrong");
	flag_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && !statusQ[0][0] && !(fault.valid && !fault.toSecure)
		&& !(wrDo && wrDec.off == gfault_pkg::OFF_RESTORE) |=> !statusQ[0][0])
		else $error("invalid context flag set without cause");
	w1c_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && nsClearBit0 && !fault.valid |=> !statusQ[0][0])
		else $error("status bit not cleared");
	restore_copy_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && sRestore && !fault.valid |=> statusQ[1][3:0] == $past(wData_r[3:0]))
		else $error("restore value not taken");
	nonsecure_attribute_flag_cap_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && fault.valid && fault.toSecure && statusQ[1] == 32'h0
		|=> syn0Q[1][5] == $past(fault.txnNonSecure))
		else $error("non-secure attribute not captured");
	ats_reserved_a: assert property (@(posedge clk) disable iff (!rst_b)
		!syn0Q[1][6] && !syn0Q[1][0] && syn0Q[0][5:4] == 2'h0)
		else $error("reserved syndrome bit set");
	ssd_hidden_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && arHs && s_axi_arprot[1] && s_axi_araddr[7:0] == gfault_pkg::OFF_SYN1
		|=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0)
		else $error("index visible to non-secure read");
	par_cap_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && trans.valid && !trans.toSecure |=> parQ[0] == $past(trans.result))
		else $error("translation result not held");
	// Secure restore must not leak into the non-secure copy
	restore_route_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && sRestore && !fault.valid |=> $stable(statusQ[0]))
		else $error("restore reached the wrong status copy");
	syn1_bank_a: assert property (@(posedge clk) disable iff (!rst_b)
		ce && fault.valid && fault.txnNonSecure && firstFault
		|=> syn1Q[0][15:0] == ($past(fault.streamIdentifier) & SID_M))
		else $error("syndrome 1 copy not chosen by transaction security");

	sec_fault_c: cover property (@(posedge clk) disable iff (!rst_b)
		ce && fault.valid && fault.toSecure);
	multi_fault_c: cover property (@(posedge clk) disable iff (!rst_b)
		statusQ[0][gfault_pkg::BIT_MULTI]);
	restore_c: cover property (@(posedge clk) disable iff (!rst_b) ce && sRestore);
	alias_read_c: cover property (@(posedge clk) disable iff (!rst_b)
		ce && arHs && !s_axi_arprot[1] && s_axi_araddr[9:8] == gfault_pkg::REGION_ALIAS);

endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the banked global fault status and syndrome registers.
// Assumes the design package is compiled first; drives AXI4-Lite and fault strobes directly.
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic sec;
		logic [8:0] kind;
		logic [31:0] exp;
	} row_t;
	localparam logic [2:0] NS = 3'h2;
	localparam logic [2:0] SEC = 3'h0;
	logic clk, rst_b, ce;
	gfault_pkg::faultEvent_t fault, ev;
	gfault_pkg::transResult_t trans;
	logic [gfault_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int failures = 0;
	int cmpCount = 0;
	row_t rows[11];

	global_fault_status_syndrome_regs i_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .fault(fault),
		.trans(trans), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmpCount++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Each bus task begins on a fresh edge so no signal is assigned twice in one step
	task automatic wr(input logic [11:0] a, input logic [2:0] p, input logic [31:0] d,
		input logic [1:0] er);
		bit aw, w, done;
		int n;
		aw = 0;
		w = 0;
		done = 0;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awprot <= p;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done && n < 100) begin
			@(posedge clk);
			n++;
			if (aw && w && s_axi_bvalid === 1'b1) begin
				done = 1;
				s_axi_bready <= 1'b0;
				chk(s_axi_bresp, er);
			end
			if (!aw && s_axi_awready === 1'b1) begin
				aw = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready === 1'b1) begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		if (!done) failures++;
	endtask

	task automatic rd(input logic [11:0] a, input logic [2:0] p, input logic [31:0] ed,
		input logic [1:0] er);
		bit ar, done;
		int n;
		ar = 0;
		done = 0;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arprot <= p;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done && n < 100) begin
			@(posedge clk);
			n++;
			if (ar && s_axi_rvalid === 1'b1) begin
				done = 1;
				s_axi_rready <= 1'b0;
				chk(s_axi_rdata, ed);
				chk(s_axi_rresp, er);
			end
			if (!ar && s_axi_arready === 1'b1) begin
				ar = 1;
				s_axi_arvalid <= 1'b0;
			end
		end
		if (!done) failures++;
	endtask

	task automatic pulse(input gfault_pkg::faultEvent_t e, input gfault_pkg::transResult_t t);
		@(posedge clk);
		fault <= e;
		trans <= t;
		@(posedge clk);
		fault <= '0;
		trans <= '0;
	endtask

	function automatic gfault_pkg::faultEvent_t mk(input logic sec, input logic [8:0] kind);
		gfault_pkg::faultEvent_t e;
		e = '0;
		e.valid = 1'b1;
		e.toSecure = sec;
		e.kind = kind;
		return e;
	endfunction

	initial begin
		#(20 * 20000);
		failures++;
		summarize();
	end

	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		fault = '0;
		trans = '0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_awprot = '0;
		s_axi_arprot = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		rd(12'h000, SEC, 32'h0000_0000, 2'h0);
		rd(12'h000, NS, 32'h0000_0000, 2'h0);
		// Rows 0 and 5 go to the non-secure copy so its clear and fault paths run
		for (int i = 0; i < 9; i++) rows[i] = '{i != 0 && i != 5, 9'(1 << i), 32'(1 << i)};
		rows[9] = '{1'b0, 9'h080, 32'h0000_0000};
		rows[10] = '{1'b0, 9'h100, 32'h0000_0100};
		foreach (rows[i]) begin
			pulse(mk(rows[i].sec, rows[i].kind), '0);
			rd(12'h000, rows[i].sec ? SEC : NS, rows[i].exp, 2'h0);
			wr(12'h000, rows[i].sec ? SEC : NS, rows[i].exp, 2'h0);
			rd(12'h000, rows[i].sec ? SEC : NS, 32'h0000_0000, 2'h0);
		end
		// Frozen clock enable must swallow an event
		@(posedge clk);
		ce <= 1'b0;
		pulse(mk(1'b0, 9'h002), '0);
		@(posedge clk);
		ce <= 1'b1;
		rd(12'h000, NS, 32'h0000_0000, 2'h0);
		pulse(mk(1'b0, 9'h002), '0);
		pulse(mk(1'b0, 9'h004), '0);
		rd(12'h000, NS, 32'h8000_0006, 2'h0);
		wr(12'h000, NS, 32'h0000_0002, 2'h0);
		wr(12'h000, NS, 32'h0000_0000, 2'h0);
		rd(12'h000, NS, 32'h8000_0004, 2'h0);
		wr(12'h004, NS, 32'h8000_0011, 2'h0);
		rd(12'h000, NS, 32'h8000_0011, 2'h0);
		rd(12'h000, SEC, 32'h0000_0000, 2'h0);
		wr(12'h004, SEC, 32'h0000_0180, 2'h0);
		rd(12'h000, SEC, 32'h0000_0180, 2'h0);
		wr(12'h104, SEC, 32'h0000_0003, 2'h0);
		rd(12'h000, NS, 32'h0000_0003, 2'h0);
		rd(12'h004, SEC, 32'h0000_0000, 2'h0);
		wr(12'h004, SEC, 32'h0000_0000, 2'h0);
		wr(12'h004, NS, 32'h0000_0000, 2'h0);
		// Secure report of a non-secure transaction, all attributes raised
		ev = mk(1'b1, 9'h001);
		{ev.txnNonSecure, ev.clientNonSecure, ev.translationOpFaultFlag} = 3'b111;
		{ev.instructionAccessFlag, ev.privilegedAccessFlag, ev.writeAccessFlag, ev.nested} = 4'hf;
		{ev.securityDeterminationIndex, ev.streamIdentifier} = 32'habcd_1234;
		pulse(ev, '0);
		rd(12'h008, SEC, 32'h0000_003e, 2'h0);
		rd(12'h008, NS, 32'h0000_0000, 2'h0);
		rd(12'h00c, NS, 32'h0000_1234, 2'h0);
		rd(12'h10c, SEC, 32'habcd_1234, 2'h0);
		rd(12'h00c, SEC, 32'h0000_0000, 2'h0);
		wr(12'h004, SEC, 32'h0000_0000, 2'h0);
		ev = mk(1'b0, 9'h002);
		{ev.clientNonSecure, ev.translationOpFaultFlag, ev.writeAccessFlag, ev.nested} = 4'hf;
		{ev.securityDeterminationIndex, ev.streamIdentifier} = 32'h0007_0042;
		pulse(ev, '0);
		rd(12'h008, NS, 32'h0000_0043, 2'h0);
		rd(12'h00c, SEC, 32'h0007_0042, 2'h0);
		rd(12'h00c, NS, 32'h0000_1234, 2'h0);
		wr(12'h00c, NS, 32'hffff_5678, 2'h0);
		rd(12'h00c, NS, 32'h0000_5678, 2'h0);
		rd(12'h10c, SEC, 32'habcd_5678, 2'h0);
		wr(12'h010, NS, 32'hdead_beef, 2'h0);
		rd(12'h010, NS, 32'hdead_beef, 2'h0);
		pulse('0, '{1'b1, 1'b1, 64'h0123_4567_89ab_cdef});
		rd(12'h014, SEC, 32'h89ab_cdef, 2'h0);
		rd(12'h018, SEC, 32'h0123_4567, 2'h0);
		rd(12'h014, NS, 32'h0000_0000, 2'h0);
		pulse('0, '{1'b1, 1'b0, 64'hfedc_ba98_7654_3210});
		rd(12'h018, NS, 32'hfedc_ba98, 2'h0);
		// Unmapped places and non-secure use of the alias
		rd(12'h01c, SEC, 32'h0000_0000, gfault_pkg::RESP_SLVERR);
		wr(12'h300, SEC, 32'hffff_ffff, gfault_pkg::RESP_SLVERR);
		rd(12'h100, NS, 32'h0000_0000, gfault_pkg::RESP_OKAY);
		// Second reset in mid-run
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd(12'h010, NS, 32'h0000_0000, 2'h0);
		rd(12'h000, NS, 32'h0000_0000, 2'h0);
		summarize();
	end
endmodule
